// File: core/vcf_cfg.svh
`ifndef VCF_CFG_SVH
`define VCF_CFG_SVH

// encoding layout
`define VCF_ENC_W          16
`define VCF_DATA_W         64
`define VCF_IDX_W          9
`define VCF_SLOT_W         7
`define VCF_ACC_BIT        0
`define VCF_IDX_LSB        1
`define VCF_IDX_MSB        9
`define VCF_TYPE_LSB       10
`define VCF_TYPE_MSB       11
`define VCF_RSVD_BIT       12
`define VCF_WID_LSB        13
`define VCF_WID_MSB        14
`define VCF_TOP_BIT        15

// slot bases and field counts per class
`define VCF_RO32_BASE      7'h00
`define VCF_RO32_CNT       9'h008
`define VCF_G32_BASE       7'h08
`define VCF_G32_CNT        9'h018
`define VCF_G32_HOLE_IDX   9'h016
`define VCF_G32_PTMR_IDX   9'h017
`define VCF_H32_BASE       7'h20
`define VCF_H32_CNT        9'h001
`define VCF_NWR_BASE       7'h21
`define VCF_NWR_CNT        9'h006
`define VCF_NWG_BASE       7'h27
`define VCF_NWG_CNT        9'h017
`define VCF_NWG_CET_IDX    9'h014
`define VCF_NWH_BASE       7'h3e
`define VCF_NWH_CNT        9'h00f
`define VCF_NWH_CET_IDX    9'h00c
`define VCF_NWC_BASE       7'h4d
`define VCF_NWC_ROOT_IDX   9'h004
`define VCF_ROOT_CNT       4
`define VCF_SLOT_LIMIT     128

// fields cleared on entry, and the kept width of 32-bit writes
`define VCF_GDT_LIM_IDX    9'h008
`define VCF_IDT_LIM_IDX    9'h009
`define VCF_SEG_FIRST_IDX  9'h003
`define VCF_SEG_LAST_IDX   9'h006
`define VCF_LIM_KEEP_W     16
`define VCF_SEG_KEEP_W     32
`define VCF_W32_KEEP_W     32

`endif

// File: core/vcf_enc_split.sv
`timescale 1ns/10ps
`include "vcf_cfg.svh"

module vcf_enc_split (
  input  wire logic [15:0]         enc,
  output vcf_pkg::vcf_width_t      width_cls,
  output vcf_pkg::vcf_ftype_t      ftype,
  output logic [8:0]               index,
  output logic                     access_hi,
  output logic                     rsvd_bad
);
  import vcf_pkg::*;

  assign width_cls = vcf_width_t'(enc[`VCF_WID_MSB:`VCF_WID_LSB]);
  assign ftype     = vcf_ftype_t'(enc[`VCF_TYPE_MSB:`VCF_TYPE_LSB]);
  assign index     = enc[`VCF_IDX_MSB:`VCF_IDX_LSB];
  assign access_hi = enc[`VCF_ACC_BIT];
  assign rsvd_bad  = enc[`VCF_TOP_BIT] | enc[`VCF_RSVD_BIT];

endmodule : vcf_enc_split

// File: core/vcf_field_decoder.sv
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "vcf_cfg.svh"

module vcf_field_decoder #(
  parameter int ROOT_CNT = `VCF_ROOT_CNT
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic [15:0]         addr,
  input  wire logic [63:0]         wdata,
  input  wire logic                wr_stb,
  input  wire logic                rd_stb,
  input  wire logic                vm_entry,
  input  wire logic                ptmr_supported,
  input  wire logic                cet_entry_supported,
  input  wire logic                cet_exit_supported,
  output logic [63:0]              rdata,
  output logic                     rsp_valid,
  output logic                     rsp_unsupported,
  output logic                     rsp_ro_reject,
  output logic [6:0]               rsp_slot,
  output vcf_pkg::vcf_width_t      rsp_width,
  output vcf_pkg::vcf_ftype_t      rsp_type,
  output logic                     entry_done
);
  import vcf_pkg::*;

  localparam int NSLOT    = int'(`VCF_NWC_BASE) + int'(`VCF_NWC_ROOT_IDX) + ROOT_CNT;
  localparam int RO32_END = int'(`VCF_RO32_BASE) + int'(`VCF_RO32_CNT);
  localparam int G32_END  = int'(`VCF_G32_BASE) + int'(`VCF_G32_CNT);
  localparam int H32_END  = int'(`VCF_H32_BASE) + int'(`VCF_H32_CNT);
  localparam int NWR_END  = int'(`VCF_NWR_BASE) + int'(`VCF_NWR_CNT);
  localparam int NWG_END  = int'(`VCF_NWG_BASE) + int'(`VCF_NWG_CNT);
  localparam int NWH_END  = int'(`VCF_NWH_BASE) + int'(`VCF_NWH_CNT);

  // refuse settings the slot space cannot serve
  if (ROOT_CNT < `VCF_ROOT_CNT) begin : g_root_low
    $error("vcf_field_decoder: ROOT_CNT below minimum");
  end
  if (NSLOT > `VCF_SLOT_LIMIT) begin : g_root_high
    $error("vcf_field_decoder: ROOT_CNT overflows slot space");
  end
  if (RO32_END > int'(`VCF_G32_BASE) || G32_END > int'(`VCF_H32_BASE)) begin : g_lay_32
    $error("vcf_field_decoder: 32-bit classes overlap");
  end
  if (H32_END > int'(`VCF_NWR_BASE) || NWR_END > int'(`VCF_NWG_BASE)) begin : g_lay_mid
    $error("vcf_field_decoder: host or read-only classes overlap");
  end
  if (NWG_END > int'(`VCF_NWH_BASE) || NWH_END > int'(`VCF_NWC_BASE)) begin : g_lay_nat
    $error("vcf_field_decoder: natural-width classes overlap");
  end

  localparam logic [6:0] GDT_LIM_SLOT = 7'(`VCF_G32_BASE + 7'(`VCF_GDT_LIM_IDX));
  localparam logic [6:0] IDT_LIM_SLOT = 7'(`VCF_G32_BASE + 7'(`VCF_IDT_LIM_IDX));
  localparam logic [6:0] SEG_FIRST    = 7'(`VCF_NWG_BASE + 7'(`VCF_SEG_FIRST_IDX));
  localparam logic [6:0] SEG_LAST     = 7'(`VCF_NWG_BASE + 7'(`VCF_SEG_LAST_IDX));

  vcf_width_t  dec_width;
  vcf_ftype_t  dec_type;
  logic [8:0]  dec_index;
  logic        dec_acc_hi;
  logic        dec_rsvd;
  logic        dec_hit;
  logic [6:0]  dec_slot;
  logic        dec_ro;

  logic [63:0]      slot_mem [NSLOT];
  wire  [63:0]      next_mem [NSLOT];
  wire  [NSLOT-1:0] sel_wr;
  wire  [NSLOT-1:0] sel_lim;
  wire  [NSLOT-1:0] sel_seg;

  vcf_enc_split u_split (
    .enc       (addr),
    .width_cls (dec_width),
    .ftype     (dec_type),
    .index     (dec_index),
    .access_hi (dec_acc_hi),
    .rsvd_bad  (dec_rsvd)
  );

  vcf_slot_map #(
    .ROOT_CNT (ROOT_CNT)
  ) u_map (
    .width_cls           (dec_width),
    .ftype               (dec_type),
    .index               (dec_index),
    .access_hi           (dec_acc_hi),
    .rsvd_bad            (dec_rsvd),
    .ptmr_supported      (ptmr_supported),
    .cet_entry_supported (cet_entry_supported),
    .cet_exit_supported  (cet_exit_supported),
    .hit                 (dec_hit),
    .slot                (dec_slot),
    .read_only           (dec_ro)
  );

  // write gating and width shaping
  wire        acc_any   = wr_stb | rd_stb;
  wire        wr_ok     = wr_stb && dec_hit && !dec_ro;
  wire        wr_is_w32 = (dec_width == VCF_W32);
  wire [63:0] wr_val    = wr_is_w32 ? {32'h0, wdata[`VCF_W32_KEEP_W-1:0]} : wdata;
  wire        next_unsup = acc_any && !dec_hit;
  wire        next_ro_rej = wr_stb && dec_hit && dec_ro;
  wire [63:0] next_rdata = (rd_stb && dec_hit) ? slot_mem[dec_slot] : 64'h0;

  // storage update, entry clearing applied after any same-cycle write
  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    localparam logic [6:0] SLOT_ID = 7'(s);
    wire [63:0] after_wr;
    assign sel_wr[s]   = wr_ok && (dec_slot == SLOT_ID);
    assign sel_lim[s]  = vm_entry && (SLOT_ID == GDT_LIM_SLOT || SLOT_ID == IDT_LIM_SLOT);
    assign sel_seg[s]  = vm_entry && SLOT_ID >= SEG_FIRST && SLOT_ID <= SEG_LAST;
    assign after_wr    = sel_wr[s] ? wr_val : slot_mem[s];
    assign next_mem[s] = sel_lim[s] ? {48'h0, after_wr[`VCF_LIM_KEEP_W-1:0]} :
                         sel_seg[s] ? {32'h0, after_wr[`VCF_SEG_KEEP_W-1:0]} :
                         after_wr;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NSLOT; i++) begin
        slot_mem[i] <= 64'h0;
      end
    end else begin
      for (int i = 0; i < NSLOT; i++) begin
        slot_mem[i] <= next_mem[i];
      end
    end
  end

  // answer stage, one short flop per output
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 64'h0;
    end else begin
      rdata <= next_rdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= acc_any;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsp_unsupported <= 1'b0;
    end else begin
      rsp_unsupported <= next_unsup;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsp_ro_reject <= 1'b0;
    end else begin
      rsp_ro_reject <= next_ro_rej;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsp_slot <= 7'h00;
    end else begin
      rsp_slot <= dec_slot;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsp_width <= VCF_W16;
    end else begin
      rsp_width <= dec_width;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsp_type <= VCF_T_CTRL;
    end else begin
      rsp_type <= dec_type;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      entry_done <= 1'b0;
    end else begin
      entry_done <= vm_entry;
    end
  end

endmodule : vcf_field_decoder

// File: core/vcf_pkg.sv
package vcf_pkg;

  typedef enum logic [1:0] {
    VCF_W16  = 2'h0,
    VCF_W64  = 2'h1,
    VCF_W32  = 2'h2,
    VCF_WNAT = 2'h3
  } vcf_width_t;

  typedef enum logic [1:0] {
    VCF_T_CTRL  = 2'h0,
    VCF_T_RO    = 2'h1,
    VCF_T_GUEST = 2'h2,
    VCF_T_HOST  = 2'h3
  } vcf_ftype_t;

endpackage : vcf_pkg

// File: core/vcf_slot_map.sv
`timescale 1ns/10ps
`include "vcf_cfg.svh"

module vcf_slot_map #(
  parameter int ROOT_CNT = `VCF_ROOT_CNT
) (
  input  vcf_pkg::vcf_width_t      width_cls,
  input  vcf_pkg::vcf_ftype_t      ftype,
  input  wire logic [8:0]          index,
  input  wire logic                access_hi,
  input  wire logic                rsvd_bad,
  input  wire logic                ptmr_supported,
  input  wire logic                cet_entry_supported,
  input  wire logic                cet_exit_supported,
  output logic                     hit,
  output logic [6:0]               slot,
  output logic                     read_only
);
  import vcf_pkg::*;

  localparam logic [8:0] NWC_CNT = 9'(`VCF_NWC_ROOT_IDX + 9'(ROOT_CNT));

  logic       is_w32;
  logic       is_nat;
  logic       hit_ro32;
  logic       hit_g32;
  logic       hit_h32;
  logic       hit_nwc;
  logic       hit_nwr;
  logic       hit_nwg;
  logic       hit_nwh;
  logic       clean;
  logic [6:0] base;

  assign is_w32   = (width_cls == VCF_W32);
  assign is_nat   = (width_cls == VCF_WNAT);
  assign clean    = !access_hi && !rsvd_bad;
  assign hit_ro32 = is_w32 && ftype == VCF_T_RO && index < `VCF_RO32_CNT;
  assign hit_g32  = is_w32 && ftype == VCF_T_GUEST && index < `VCF_G32_CNT
                    && index != `VCF_G32_HOLE_IDX
                    && (index != `VCF_G32_PTMR_IDX || ptmr_supported);
  assign hit_h32  = is_w32 && ftype == VCF_T_HOST && index < `VCF_H32_CNT;
  assign hit_nwc  = is_nat && ftype == VCF_T_CTRL && index < NWC_CNT;
  assign hit_nwr  = is_nat && ftype == VCF_T_RO && index < `VCF_NWR_CNT;
  assign hit_nwg  = is_nat && ftype == VCF_T_GUEST && index < `VCF_NWG_CNT
                    && (index < `VCF_NWG_CET_IDX || cet_entry_supported);
  assign hit_nwh  = is_nat && ftype == VCF_T_HOST && index < `VCF_NWH_CNT
                    && (index < `VCF_NWH_CET_IDX || cet_exit_supported);

  assign base = hit_ro32 ? `VCF_RO32_BASE :
                hit_g32  ? `VCF_G32_BASE  :
                hit_h32  ? `VCF_H32_BASE  :
                hit_nwr  ? `VCF_NWR_BASE  :
                hit_nwg  ? `VCF_NWG_BASE  :
                hit_nwh  ? `VCF_NWH_BASE  : `VCF_NWC_BASE;

  assign hit       = clean && (hit_ro32 | hit_g32 | hit_h32 | hit_nwc
                               | hit_nwr | hit_nwg | hit_nwh);
  assign slot      = hit ? 7'(base + index[6:0]) : 7'h00;
  assign read_only = hit_ro32 | hit_nwr;

endmodule : vcf_slot_map

// File: verif/tb.sv
`timescale 1ns/10ps
`define CHK(n, e, v) begin checks++; if ((v) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, v); end end
module tb;
  logic        clk, nrst, vm_entry, ptmr, cet, wr_stb, rd_stb, rsp_unsupported, u;
  logic [15:0] addr;
  logic [63:0] wdata, rdata, d;
  int          mismatches, checks;
  vcf_field_decoder #(.ROOT_CNT(4)) vcf_field_decoder_i (.clk, .nrst, .addr, .wdata,
    .wr_stb, .rd_stb, .vm_entry, .ptmr_supported(ptmr), .cet_entry_supported(cet),
    .cet_exit_supported(cet), .rdata, .rsp_valid(), .rsp_unsupported, .rsp_ro_reject(),
    .rsp_slot(), .rsp_width(), .rsp_type(), .entry_done());
  vcf_issuer vcf_issuer_i (.clk, .rdata, .rsp_unsupported, .addr, .wdata, .wr_stb, .rd_stb);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic rchk(input logic [15:0] a, input logic [63:0] e, input logic eu);
    vcf_issuer_i.rd(a, d, u);
    `CHK("rdata", e, d)
    `CHK("unsupported", eu, u)
  endtask : rchk
  task automatic t_rw;
    logic [15:0] a [5] = '{16'h6800, 16'h6c00, 16'h6000, 16'h600e, 16'h4800};
    logic [63:0] p;
    for (int i = 0; i < 5; i++) begin
      p = {4{a[i]}};
      vcf_issuer_i.wr(a[i], p);
      rchk(a[i], (a[i][14:13] == 2'h2) ? {32'h0, p[31:0]} : p, 1'b0);
    end
  endtask : t_rw
  task automatic t_unsup;
    logic [15:0] a [9] = '{16'h6801, 16'h6010, 16'h4c02, 16'h4410, 16'h640c, 16'h482e,
      16'h6828, 16'h482c, 16'h6c18};
    for (int i = 0; i < 9; i++) rchk(a[i], 64'h0, 1'b1);
  endtask : t_unsup
  task automatic t_sup;
    logic [15:0] a [9] = '{16'h482e, 16'h6828, 16'h682c, 16'h4400, 16'h440e, 16'h6400,
      16'h640a, 16'h4c00, 16'h6c1c};
    ptmr <= 1'b1;
    cet <= 1'b1;
    for (int i = 0; i < 9; i++) rchk(a[i], 64'h0, 1'b0);
    vcf_issuer_i.wr(16'h6400, 64'h1);
    rchk(16'h6400, 64'h0, 1'b0);
  endtask : t_sup
  task automatic t_entry;
    vcf_issuer_i.wr(16'h4810, {64{1'b1}});
    vcf_issuer_i.wr(16'h6806, {64{1'b1}});
    vcf_issuer_i.wr(16'h680c, {64{1'b1}});
    vcf_issuer_i.wr(16'h680e, {64{1'b1}});
    vm_entry <= 1'b1;
    vcf_issuer_i.idle;
    vm_entry <= 1'b0;
    vcf_issuer_i.idle;
    rchk(16'h4810, 64'h0000_0000_0000_ffff, 1'b0);
    rchk(16'h6806, 64'h0000_0000_ffff_ffff, 1'b0);
    rchk(16'h680c, 64'h0000_0000_ffff_ffff, 1'b0);
    rchk(16'h680e, {64{1'b1}}, 1'b0);
    vm_entry <= 1'b1;
    vcf_issuer_i.wr(16'h4812, {64{1'b1}});
    vm_entry <= 1'b0;
    rchk(16'h4812, 64'h0000_0000_0000_ffff, 1'b0);
  endtask : t_entry
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    #20000;
    mismatches++;
    end_sim;
  end
  initial begin
    nrst = 1'b0;
    vm_entry = 1'b0;
    ptmr = 1'b0;
    cet = 1'b0;
    mismatches = 0;
    checks = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_rw;
    t_unsup;
    t_sup;
    t_entry;
    end_sim;
  end
endmodule : tb

// File: verif/vcf_chk_sva.sv
`timescale 1ns/10ps
module vcf_chk (
  input logic                clk,
  input logic                nrst,
  input logic [15:0]         addr,
  input logic [63:0]         wdata,
  input logic                wr_stb,
  input logic                rd_stb,
  input logic                vm_entry,
  input logic                ptmr_supported,
  input logic [63:0]         rdata,
  input logic                rsp_valid,
  input logic                rsp_unsupported,
  input logic                rsp_ro_reject,
  input logic [6:0]          rsp_slot,
  input vcf_pkg::vcf_width_t rsp_width,
  input vcf_pkg::vcf_ftype_t rsp_type,
  input logic                entry_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_wr; wr_stb && addr == 16'h6800; endsequence
  sequence s_rd; rd_stb && addr == 16'h6800; endsequence
  property p_wid; rsp_valid |-> rsp_width == $past(addr[14:13]); endproperty
  a_wid: assert property (p_wid) else $error("width class mismatch");
  property p_type; rsp_valid |-> rsp_type == $past(addr[11:10]); endproperty
  a_type: assert property (p_type) else $error("field type mismatch");
  property p_rbw; s_wr ##1 s_rd |=> rdata == $past(wdata, 2); endproperty
  a_rbw: assert property (p_rbw) else $error("guest field readback wrong");
  property p_odd;
    (wr_stb || rd_stb) && addr[0] |=> rsp_valid && rsp_unsupported && rdata == 64'h0;
  endproperty
  a_odd: assert property (p_odd) else $error("odd encoding accepted");
  property p_ro;
    wr_stb && addr[15:10] == 6'h19 && addr[9:1] < 9'h006 && !addr[0] |=> rsp_ro_reject;
  endproperty
  a_ro: assert property (p_ro) else $error("read-only write not rejected");
  property p_h32; rd_stb && addr[15:10] == 6'h13 && addr[9:0] != 10'h0 |=> rsp_unsupported;
  endproperty
  a_h32: assert property (p_h32) else $error("extra host field accepted");
  property p_ptmr;
    rd_stb && addr == 16'h482e |=> rsp_unsupported == !$past(ptmr_supported);
  endproperty
  a_ptmr: assert property (p_ptmr) else $error("timer field gating wrong");
  property p_slot; rsp_valid && !rsp_unsupported && $past(addr[15:10]) == 6'h11
    |-> rsp_slot == {4'h0, $past(addr[3:1])}; endproperty
  a_slot: assert property (p_slot) else $error("read-only slot wrong");
  property p_unsup; rsp_unsupported |-> rsp_valid && rsp_slot == 7'h0; endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported with slot");
  property p_entry; vm_entry |=> entry_done; endproperty
  a_entry: assert property (p_entry) else $error("entry not done");
  sequence s_ent_wr; vm_entry && wr_stb && addr == 16'h4812; endsequence
  sequence s_lim_rd; rd_stb && addr == 16'h4812; endsequence
  property p_lim; s_ent_wr ##1 s_lim_rd |=> rdata[63:16] == 48'h0; endproperty
  a_lim: assert property (p_lim) else $error("limit not cleared on entry");
endmodule : vcf_chk
bind vcf_field_decoder vcf_chk vcf_chk_i (.clk, .nrst, .addr, .wdata, .wr_stb, .rd_stb,
  .vm_entry, .ptmr_supported, .rdata, .rsp_valid, .rsp_unsupported, .rsp_ro_reject,
  .rsp_slot, .rsp_width, .rsp_type, .entry_done);

// File: verif/vcf_issuer.sv
`timescale 1ns/10ps
module vcf_issuer (
  input  logic        clk,
  input  logic [63:0] rdata,
  input  logic        rsp_unsupported,
  output logic [15:0] addr,
  output logic [63:0] wdata,
  output logic        wr_stb,
  output logic        rd_stb
);
  initial begin
    addr   <= 16'h0;
    wdata  <= 64'h0;
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
  end
  // entered right after a rising edge; a write strobe stays up until the next call
  task automatic wr(input logic [15:0] a, input logic [63:0] d);
    addr   <= a;
    wdata  <= d;
    rd_stb <= 1'b0;
    wr_stb <= 1'b1;
    @(posedge clk);
  endtask : wr
  task automatic idle;
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    @(posedge clk);
  endtask : idle
  task automatic rd(input logic [15:0] a, output logic [63:0] d, output logic u);
    addr   <= a;
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
    u = rsp_unsupported;
    @(posedge clk);
  endtask : rd
endmodule : vcf_issuer
